// ==== dfp_host.sv ====
// Host model: one-cycle read or write strobes on the register bus.
// Assumes the bench calls acc; strobes change at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module dfp_host (
    input  wire logic        clock,     // Board clock
    output var  logic [15:0] reg_addr,  // Offset
    output var  logic        reg_wr,    // Write strobe
    output var  logic        reg_rd,    // Read strobe
    output var  logic [31:0] reg_wdata, // Write data
    input  wire logic [31:0] reg_rdata, // Read data
    input  wire logic        reg_ack    // Access done
);
    initial begin
        reg_addr = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 32'h0000_0000;
    end
    task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] dat,
                       output logic [31:0] q, output logic ok);
        @(negedge clock);
        reg_addr = a;
        reg_wdata = dat;
        reg_wr = w;
        reg_rd = !w;
        @(negedge clock);
        // Acknowledge stands only until the next rising edge; read data holds until the next read strobe
        q = reg_rdata;
        ok = reg_ack;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        // Released lines stop showing the last value
        reg_addr = ~a;
        reg_wdata = ~dat;
        @(negedge clock);
    endtask
endmodule // dfp_host
`default_nettype wire

// ==== dfp_map.vh ====
// Register offsets, field positions and reset values of the front panel register bank.
// Assumes a 16-bit register address from the board's bus decoder.
`ifndef DFP_MAP_VH
`define DFP_MAP_VH
`define DFP_OFF_FPIO_DATA    16'h8118
`define DFP_OFF_FPIO_CTRL    16'h811C
`define DFP_OFF_CHAN_MASK    16'h8120
`define DFP_OFF_FW_REV       16'h8124
`define DFP_OFF_EVT_STORED   16'h812C
`define DFP_OFF_MON_DAC      16'h8138
`define DFP_OFF_BOARD_INFO   16'h8140
`define DFP_OFF_MON_MODE     16'h8144
`define DFP_OFF_EVT_SIZE     16'h814C
`define DFP_BIT_TEST_MODE    15
`define DFP_BIT_TEST_LEVEL   14
`define DFP_BIT_LATCH_EXT    9
`define DFP_LVDS_MODE_HI     7
`define DFP_LVDS_MODE_LO     6
`define DFP_DIR_HI           5
`define DFP_DIR_LO           2
`define DFP_BIT_OUT_HIZ      1
`define DFP_BIT_TTL          0
`define DFP_CTRL_WMASK       16'hC2FF
`define DFP_LVDS_GPIO        2'h0
`define DFP_LVDS_PROG        2'h1
`define DFP_LVDS_PATTERN     2'h2
`define DFP_MON_MAJORITY     3'h0
`define DFP_MON_SAWTOOTH     3'h1
`define DFP_MON_RESERVED     3'h2
`define DFP_MON_OCCUPANCY    3'h3
`define DFP_MON_VOLTAGE      3'h4
`define DFP_RST_CTRL         16'h0000
`define DFP_RST_CHAN_MASK    8'h00
`define DFP_RST_MON_DAC      12'h000
`define DFP_RST_MON_MODE     3'h0
`define DFP_RST_FPIO_DATA    16'h0000
`endif

// ==== dfp_pattern_latch.v ====
// Captures the LVDS pattern on the selected trigger for the event header.
// Assumes triggers are single-cycle pulses on clock.
`timescale 1ns/1ps
`default_nettype none
module dfp_pattern_latch (
    input  wire        clock,        // Board clock
    input  wire        sys_rst,      // Async reset, active high
    input  wire        latch_ext,    // 1: external trigger edge, 0: internal trigger
    input  wire        ext_trig,     // Synchronised external trigger level
    input  wire        int_trig,     // Internal trigger pulse
    input  wire [15:0] lvds_level,   // Synchronised LVDS levels
    output reg  [15:0] pattern,      // Captured pattern field
    output reg         pattern_valid // One-cycle pulse on capture
);
    reg  ext_prev;
    wire ext_rise = ext_trig & ~ext_prev;
    wire take     = latch_ext ? ext_rise : int_trig;
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ext_prev      <= 1'b0;
            pattern       <= 16'h0000;
            pattern_valid <= 1'b0;
        end else begin
            ext_prev      <= ext_trig;
            pattern_valid <= take;
            if (take) begin
                pattern <= lvds_level;
            end
        end
    end
endmodule // dfp_pattern_latch
`default_nettype wire

// ==== dfp_regs.v ====
// Front panel I/O, channel mask, monitor and board information register bank.
// Assumes a board bus decoder gives a one-cycle read or write strobe with a 16-bit offset.
`include "dfp_map.vh"
`timescale 1ns/1ps
`default_nettype none
module dfp_regs #(
    parameter [15:0] REV_DATE   = 16'h0000, // Arbitrary value
    parameter [7:0]  REV_MAJOR  = 8'h00,    // Arbitrary value
    parameter [7:0]  REV_MINOR  = 8'h00,    // Arbitrary value
    parameter [7:0]  MEM_SIZE   = 8'h01,    // Memory size per channel
    parameter [7:0]  BOARD_TYPE = 8'h5A     // Arbitrary value
) (
    input  wire        clock,            // Board clock, 10 MHz
    input  wire        sys_rst,          // Async reset, active high
    input  wire [15:0] reg_addr,         // Register offset
    input  wire        reg_wr,           // Write strobe, one cycle
    input  wire        reg_rd,           // Read strobe, one cycle
    input  wire [31:0] reg_wdata,        // Write data
    output reg  [31:0] reg_rdata,        // Read data, valid with reg_ack
    output reg         reg_ack,          // Access done, one cycle
    input  wire        run_active,       // Acquisition running
    input  wire        trig_activity,    // Trigger out request after enable mask
    input  wire        int_trig,         // Internal trigger pulse
    input  wire        ext_trig_pin,     // External trigger pin
    input  wire [15:0] lvds_in,          // LVDS pin levels
    output reg  [15:0] lvds_out,         // LVDS output data
    output reg  [15:0] lvds_oe,          // LVDS output enables
    output reg         trigger_output,   // Trigger output level
    output reg         trig_clk_oe,      // Trigger and clock output enable
    output reg         trigger_clock_front_io_ttl, // 1: TTL levels, 0: NIM
    output reg  [7:0]  chan_enable,      // Channel mask in effect
    output reg  [11:0] mon_dac,          // Monitor DAC code
    output reg  [2:0]  mon_mode,         // Monitor mode in effect
    output reg  [1:0]  lvds_mode,        // LVDS mode in effect
    output wire [15:0] pattern,          // Event header pattern field
    output wire        pattern_valid,    // Pattern captured pulse
    input  wire [31:0] stored_count_in,  // Events in output buffer
    input  wire [31:0] max_buffers,      // Buffers under current size setting
    input  wire [31:0] event_words_in    // Words in next event
);
    localparam S_IDLE = 2'b01;
    localparam S_RUN  = 2'b10;

    reg  [15:0] ctrl;
    reg  [7:0]  mask_reg;
    reg  [15:0] io_data;
    reg  [1:0]  state;
    reg  [31:0] stored_count;
    reg  [31:0] event_words;
    wire [15:0] lvds_sync;
    wire        ext_sync;

    function [15:0] group_oe;
        input [3:0] dir;
        begin
            group_oe = {{4{dir[3]}}, {4{dir[2]}}, {4{dir[1]}}, {4{dir[0]}}};
        end
    endfunction

    function hit;
        input [15:0] addr;
        input [15:0] off;
        begin
            hit = (addr == off);
        end
    endfunction

    dfp_sync3 #(.W(17)) u_sync (
        .clock   (clock),
        .sys_rst (sys_rst),
        .din     ({ext_trig_pin, lvds_in}),
        .dout    ({ext_sync, lvds_sync})
    );

    dfp_pattern_latch u_pat (
        .clock         (clock),
        .sys_rst       (sys_rst),
        .latch_ext     (ctrl[`DFP_BIT_LATCH_EXT]),
        .ext_trig      (ext_sync),
        .int_trig      (int_trig),
        .lvds_level    (lvds_sync),
        .pattern       (pattern),
        .pattern_valid (pattern_valid)
    );

    // Run tracking so the mask in effect is frozen during a run
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state       <= S_IDLE;
            chan_enable <= `DFP_RST_CHAN_MASK;
        end else begin
            case (state)
                S_IDLE: begin
                    chan_enable <= mask_reg;
                    if (run_active) begin
                        state <= S_RUN;
                    end
                end
                S_RUN: begin
                    if (!run_active) begin
                        state <= S_IDLE;
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // Register writes
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl     <= `DFP_RST_CTRL;
            mask_reg <= `DFP_RST_CHAN_MASK;
            io_data  <= `DFP_RST_FPIO_DATA;
            mon_dac  <= `DFP_RST_MON_DAC;
            mon_mode <= `DFP_RST_MON_MODE;
        end else if (reg_wr) begin
            if (hit(reg_addr, `DFP_OFF_FPIO_CTRL)) begin
                ctrl <= reg_wdata[15:0] & `DFP_CTRL_WMASK;
            end
            if (hit(reg_addr, `DFP_OFF_CHAN_MASK) && state == S_IDLE) begin
                mask_reg <= reg_wdata[7:0];
            end
            if (hit(reg_addr, `DFP_OFF_FPIO_DATA)) begin
                io_data <= reg_wdata[15:0];
            end
            if (hit(reg_addr, `DFP_OFF_MON_DAC)) begin
                mon_dac <= reg_wdata[11:0];
            end
            if (hit(reg_addr, `DFP_OFF_MON_MODE)) begin
                // Reserved code is refused so the monitor keeps its mode
                if (reg_wdata[2:0] != `DFP_MON_RESERVED &&
                    reg_wdata[2:0] <= `DFP_MON_VOLTAGE) begin
                    mon_mode <= reg_wdata[2:0];
                end
            end
        end
    end

    // Front panel outputs and status capture
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            lvds_mode                  <= `DFP_LVDS_GPIO;
            lvds_oe                    <= 16'h0000;
            lvds_out                   <= 16'h0000;
            trigger_output             <= 1'b0;
            trig_clk_oe                <= 1'b0;
            trigger_clock_front_io_ttl <= 1'b0;
            stored_count               <= 32'h0000_0000;
            event_words                <= 32'h0000_0000;
        end else begin
            lvds_mode <= ctrl[`DFP_LVDS_MODE_HI:`DFP_LVDS_MODE_LO];
            case (ctrl[`DFP_LVDS_MODE_HI:`DFP_LVDS_MODE_LO])
                `DFP_LVDS_GPIO: begin
                    lvds_oe <= group_oe(ctrl[`DFP_DIR_HI:`DFP_DIR_LO]);
                end
                default: begin
                    lvds_oe <= 16'h0000;
                end
            endcase
            lvds_out <= io_data;
            if (ctrl[`DFP_BIT_TEST_MODE]) begin
                trigger_output <= ctrl[`DFP_BIT_TEST_LEVEL];
            end else begin
                trigger_output <= trig_activity;
            end
            trig_clk_oe                <= ~ctrl[`DFP_BIT_OUT_HIZ];
            trigger_clock_front_io_ttl <= ctrl[`DFP_BIT_TTL];
            stored_count <= (stored_count_in > max_buffers) ? max_buffers
                                                            : stored_count_in;
            event_words  <= event_words_in;
        end
    end

    // Read path, answered one cycle after the strobe
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 32'h0000_0000;
            reg_ack   <= 1'b0;
        end else begin
            reg_ack <= reg_rd | reg_wr;
            if (reg_rd) begin
                case (reg_addr)
                    `DFP_OFF_FPIO_DATA:  reg_rdata <= {16'h0000, lvds_sync};
                    `DFP_OFF_FPIO_CTRL:  reg_rdata <= {16'h0000, ctrl};
                    `DFP_OFF_CHAN_MASK:  reg_rdata <= {24'h00_0000, mask_reg};
                    `DFP_OFF_FW_REV:     reg_rdata <= {REV_DATE, REV_MAJOR, REV_MINOR};
                    `DFP_OFF_EVT_STORED: reg_rdata <= stored_count;
                    `DFP_OFF_MON_DAC:    reg_rdata <= {20'h0_0000, mon_dac};
                    `DFP_OFF_BOARD_INFO: reg_rdata <= {16'h0000, MEM_SIZE, BOARD_TYPE};
                    `DFP_OFF_MON_MODE:   reg_rdata <= {29'h0000_0000, mon_mode};
                    `DFP_OFF_EVT_SIZE:   reg_rdata <= event_words;
                    default:             reg_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule // dfp_regs
`default_nettype wire

// ==== dfp_regs_chk_sva.sv ====
// Checker for the front panel register bank, seeing only its ports.
// Assumes the bind below; control outputs settle two edges after a write strobe.
`timescale 1ns/1ps
`default_nettype none
module dfp_regs_chk (
    input wire logic        clock,                      // Board clock
    input wire logic        sys_rst,                    // Async reset
    input wire logic [15:0] reg_addr,                   // Offset
    input wire logic        reg_wr,                     // Write strobe
    input wire logic        reg_rd,                     // Read strobe
    input wire logic [31:0] reg_wdata,                  // Write data
    input wire logic [31:0] reg_rdata,                  // Read data
    input wire logic        run_active,                 // Run level
    input wire logic [31:0] max_buffers,                // Buffer limit
    input wire logic        trigger_output,             // Trigger out
    input wire logic        trig_clk_oe,                // Output enable
    input wire logic        trigger_clock_front_io_ttl, // Level select
    input wire logic [15:0] lvds_oe,                    // LVDS enables
    input wire logic [1:0]  lvds_mode,                  // LVDS mode
    input wire logic [7:0]  chan_enable,                // Mask in effect
    input wire logic [11:0] mon_dac,                    // DAC code
    input wire logic [2:0]  mon_mode                    // Monitor mode
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    wire        ctl = reg_wr && reg_addr == 16'h811C;
    wire [15:0] d   = reg_wdata[15:0];
    wire [15:0] oe  = {{4{d[5]}}, {4{d[4]}}, {4{d[3]}}, {4{d[2]}}};
    test_level_a:
        assert property (ctl && d[15] |-> ##2 trigger_output == $past(d[14], 2))
        else $error("trigger output misses test level");
    out_hiz_a:
        assert property (ctl |-> ##2 trig_clk_oe == !$past(d[1], 2))
        else $error("output enable wrong");
    level_std_a:
        assert property (ctl |-> ##2 trigger_clock_front_io_ttl == $past(d[0], 2))
        else $error("level select wrong");
    group_dir_a:
        assert property (ctl && d[7:6] != 2'b11 |-> ##2
            lvds_oe == (($past(d[7:6], 2) == 2'b00) ? $past(oe, 2) : 16'h0000))
        else $error("lvds enables wrong");
    lvds_mode_a:
        assert property (ctl && d[7:6] != 2'b11 |-> ##2 lvds_mode == $past(d[7:6], 2))
        else $error("lvds mode wrong");
    mask_hold_a:
        assert property (run_active && $past(run_active) && $past(run_active, 2)
            |-> $stable(chan_enable))
        else $error("mask moved during run");
    count_bound_a:
        assert property (reg_rd && reg_addr == 16'h812C |=> reg_rdata <= max_buffers)
        else $error("stored count above limit");
    mode_refuse_a:
        assert property (reg_wr && reg_addr == 16'h8144
            && (reg_wdata[2:0] == 3'h2 || reg_wdata[2:0] > 3'h4) |=> $stable(mon_mode))
        else $error("bad monitor mode stored");
    dac_store_a:
        assert property (reg_wr && reg_addr == 16'h8138
            |-> ##2 mon_dac == $past(reg_wdata[11:0], 2))
        else $error("dac code not stored");
endmodule // dfp_regs_chk
bind dfp_regs dfp_regs_chk chk (
    .clock, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .run_active, .max_buffers, .trigger_output, .trig_clk_oe,
    .trigger_clock_front_io_ttl, .lvds_oe, .lvds_mode, .chan_enable, .mon_dac, .mon_mode
);
`default_nettype wire

// ==== dfp_sync3.v ====
// Three-stage synchroniser with agreement filter for a bus of pin inputs.
// Assumes inputs are asynchronous to clock.
`timescale 1ns/1ps
`default_nettype none
module dfp_sync3 #(
    parameter W = 16
) (
    input  wire         clock,   // Board clock
    input  wire         sys_rst, // Async reset, active high
    input  wire [W-1:0] din,     // Asynchronous input
    output reg  [W-1:0] dout     // Filtered, synchronised value
);
    reg [W-1:0] stage1;
    reg [W-1:0] stage2;
    reg [W-1:0] stage3;
    integer i;
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            stage1 <= {W{1'b0}};
            stage2 <= {W{1'b0}};
            stage3 <= {W{1'b0}};
            dout   <= {W{1'b0}};
        end else begin
            stage1 <= din;
            stage2 <= stage1;
            stage3 <= stage2;
            // A change counts once the second and third stages agree
            for (i = 0; i < W; i = i + 1) begin
                if (stage2[i] == stage3[i]) begin
                    dout[i] <= stage3[i];
                end
            end
        end
    end
endmodule // dfp_sync3
`default_nettype wire

// ==== test_digitizer_frontpanel_and_info_regs.sv ====
// Testbench for the front panel register bank.
// Assumes dfp_host for bus cycles; inputs change at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module test_digitizer_frontpanel_and_info_regs;
    logic        clock, sys_rst, reg_wr, reg_rd, reg_ack, run_active;
    logic        trig_activity, int_trig, ext_trig_pin, trigger_output;
    logic        trig_clk_oe, trigger_clock_front_io_ttl, pattern_valid;
    logic [15:0] reg_addr, lvds_in, lvds_out, lvds_oe, pattern;
    logic [31:0] reg_wdata, reg_rdata, stored_count_in, max_buffers, event_words_in;
    logic [11:0] mon_dac;
    logic [7:0]  chan_enable;
    logic [2:0]  mon_mode, m;
    logic [1:0]  lvds_mode;
    int          n_mismatch, compares, cycles, i;
    // Identity parameters carry arbitrary values
    dfp_regs #(.REV_DATE(16'h2A3B), .REV_MAJOR(8'h05), .REV_MINOR(8'h06),
               .MEM_SIZE(8'h02), .BOARD_TYPE(8'h3C)) dut (
        .clock, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
        .reg_ack, .run_active, .trig_activity, .int_trig, .ext_trig_pin, .lvds_in,
        .lvds_out, .lvds_oe, .trigger_output, .trig_clk_oe, .trigger_clock_front_io_ttl,
        .chan_enable, .mon_dac, .mon_mode, .lvds_mode, .pattern, .pattern_valid,
        .stored_count_in, .max_buffers, .event_words_in);
    dfp_host host (.clock, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_ack);
    task automatic close_out;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] dat);
        logic [31:0] q;
        logic        ok;
        host.acc(1'b1, a, dat, q, ok);
        chk({31'h0, ok}, 32'h1);
        @(negedge clock);
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic        ok;
        host.acc(1'b0, a, 32'h0, q, ok);
        chk({31'h0, ok}, 32'h1);
        chk(q, exp);
    endtask
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_mismatch = n_mismatch + 1;
            close_out;
        end
    end
    initial begin
        {sys_rst, run_active, trig_activity, int_trig, ext_trig_pin} = 5'b10000;
        lvds_in = 16'h0000;
        stored_count_in = 32'h7;
        max_buffers = 32'h5;
        event_words_in = 32'h0000_0123;
        {n_mismatch, compares, cycles} = 0;
        repeat (5) @(negedge clock);
        sys_rst = 1'b0;
        rd(16'h8118, 32'h0);
        rd(16'h811C, 32'h0);
        rd(16'h8120, 32'h0);
        rd(16'h8124, 32'h2A3B_0506);
        rd(16'h8140, 32'h0000_023C);
        rd(16'h8100, 32'h0);
        wr(16'h8124, 32'hFFFF_FFFF);
        rd(16'h8124, 32'h2A3B_0506);
        wr(16'h811C, 32'h0000_FFBF);
        rd(16'h811C, 32'h0000_C2BF);
        chk({trigger_output, trig_clk_oe, trigger_clock_front_io_ttl, lvds_mode, lvds_oe},
            {1'b1, 1'b0, 1'b1, 2'h2, 16'h0000});
        for (i = 0; i < 3; i++) begin
            wr(16'h811C, {16'h0, 8'h80, i[1:0], 6'b10_1000});
            chk({trigger_output, trig_clk_oe, lvds_mode, lvds_oe},
                {1'b0, 1'b1, i[1:0], (i == 0) ? 16'hF0F0 : 16'h0000});
        end
        wr(16'h811C, 32'h0);
        trig_activity = 1'b1;
        repeat (3) @(negedge clock);
        chk({31'h0, trigger_output}, 32'h1);
        trig_activity = 1'b0;
        repeat (3) @(negedge clock);
        chk({31'h0, trigger_output}, 32'h0);
        wr(16'h8118, 32'h0000_A5C3);
        chk({16'h0, lvds_out}, 32'h0000_A5C3);
        lvds_in = 16'h3C5A;
        repeat (6) @(negedge clock);
        rd(16'h8118, 32'h0000_3C5A);
        int_trig = 1'b1;
        @(negedge clock);
        int_trig = 1'b0;
        chk({15'h0, pattern_valid, pattern}, 32'h0001_3C5A);
        @(negedge clock);
        wr(16'h811C, 32'h0000_0200);
        lvds_in = 16'h0F69;
        repeat (6) @(negedge clock);
        ext_trig_pin = 1'b1;
        repeat (8) @(negedge clock);
        chk({16'h0, pattern}, 32'h0000_0F69);
        wr(16'h8120, 32'h0000_00A5);
        chk({24'h0, chan_enable}, 32'h0000_00A5);
        run_active = 1'b1;
        @(negedge clock);
        // Host writes the mask mid-run on purpose
        wr(16'h8120, 32'h0000_003C);
        chk({24'h0, chan_enable}, 32'h0000_00A5);
        run_active = 1'b0;
        repeat (3) @(negedge clock);
        rd(16'h8120, 32'h0000_00A5);
        rd(16'h812C, 32'h5);
        stored_count_in = 32'h3;
        @(negedge clock);
        rd(16'h812C, 32'h3);
        rd(16'h814C, 32'h0000_0123);
        wr(16'h8138, 32'hFFFF_FABC);
        rd(16'h8138, 32'h0000_0ABC);
        chk({20'h0, mon_dac}, 32'h0000_0ABC);
        m = 3'h0;
        for (i = 7; i >= 0; i--) begin
            wr(16'h8144, i);
            if (i != 2 && i < 5) m = i[2:0];
            rd(16'h8144, {29'h0, m});
        end
        close_out;
    end
endmodule // test_digitizer_frontpanel_and_info_regs
`default_nettype wire
